// File: core/qdl_pkg.sv
// shared constants of the quad code loader link and its two ends
package qdl_pkg;
  // command word layout
  localparam int unsigned WORD_W       = 11;
  localparam int unsigned CODE_W       = 8;
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned SEL_W        = 2;
  localparam int unsigned LEVEL_W      = 9;
  localparam int unsigned BITCNT_W     = 4;
  localparam int unsigned SEL_HI_POS   = 10;
  localparam int unsigned SEL_LO_POS   = 9;
  localparam int unsigned SPAN_POS     = 8;
  localparam int unsigned CODE_MSB_POS = 7;
  localparam int unsigned CODE_LSB_POS = 0;
  localparam logic [BITCNT_W-1:0] BITS_FULL = 4'hB;

  // reset values
  localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
  localparam logic              SPAN_RESET = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RESET = 11'h000;

  // pin synchroniser depth, last stage kept for edge detection
  localparam int unsigned SYNC_DEPTH = 3;

  // host timing
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned LINK_HALF_NS     = 500;
  localparam int unsigned STROBE_PULSE_NS  = 250;
  localparam int unsigned LINK_HALF_CYC    = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_PULSE_CYC = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W          = 5;
  localparam logic [TIMER_W-1:0] HALF_RELOAD  = TIMER_W'(LINK_HALF_CYC - 1);
  localparam logic [TIMER_W-1:0] PULSE_RELOAD = TIMER_W'(STROBE_PULSE_CYC - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO   = 5'h00;

  // host register map, avalon word addresses
  localparam int unsigned AVS_ADDR_W     = 2;
  localparam int unsigned AVS_DATA_W     = 32;
  localparam logic [AVS_ADDR_W-1:0] REG_CMD    = 2'h0;
  localparam logic [AVS_ADDR_W-1:0] REG_CTRL   = 2'h1;
  localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 2'h2;
  localparam int unsigned CTRL_HOLD_POS  = 0;
  localparam int unsigned CTRL_PULSE_POS = 1;
  localparam int unsigned STAT_BUSY_POS  = 0;
  localparam int unsigned STAT_PEND_POS  = 1;
  localparam int unsigned STAT_UPD_POS   = 2;
  localparam logic [AVS_DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
endpackage : qdl_pkg

// File: core/qdl_link_if.sv
// three-wire serial link plus update strobe between host and converter
`timescale 1ns/100ps
`default_nettype none
interface qdl_link_if;
  logic ser_clk;
  logic ser_data;
  logic load_n;
  logic output_update_strobe_n;

  modport dev
  (
    input ser_clk,
    input ser_data,
    input load_n,
    input output_update_strobe_n
  );

  modport host
  (
    output ser_clk,
    output ser_data,
    output load_n,
    output output_update_strobe_n
  );
endinterface : qdl_link_if
`default_nettype wire

// File: core/qdl_device.sv
// converter end: serial command receiver and four double-buffered code channels
//
// Contract
// - reset clears every channel code to zero
// - code unsigned 0..255, level scales with span
// - shift one bit per falling clock, load high
// - load low copies word to selected latch
// - update low: output follows at load fall
// - update high holds; update falling updates outputs
// - words arrive most significant bit first
// - two eight-clock bursts form one word
// - select 00..11 picks channel 0..3
// - span bit doubles that channel's output range
// - word is eleven bits: select, span, code
`timescale 1ns/100ps
`default_nettype none
module qdl_device
  import qdl_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  qdl_link_if.dev                 link,
  output logic [CODE_W-1:0]       channel_out_0,
  output logic [CODE_W-1:0]       channel_out_1,
  output logic [CODE_W-1:0]       channel_out_2,
  output logic [CODE_W-1:0]       channel_out_3,
  output logic                    span_double_0,
  output logic                    span_double_1,
  output logic                    span_double_2,
  output logic                    span_double_3,
  output logic [LEVEL_W-1:0]      channel_level_0,
  output logic [LEVEL_W-1:0]      channel_level_1,
  output logic [LEVEL_W-1:0]      channel_level_2,
  output logic [LEVEL_W-1:0]      channel_level_3,
  output logic                    load_event,
  output logic                    short_word
);

  typedef struct packed {
    logic [SYNC_DEPTH-1:0]           clk_sync;
    logic [SYNC_DEPTH-1:0]           data_sync;
    logic [SYNC_DEPTH-1:0]           load_sync;
    logic [SYNC_DEPTH-1:0]           upd_sync;
    logic [WORD_W-1:0]               shift;
    logic [BITCNT_W-1:0]             bit_count;
    logic [NUM_CH-1:0][CODE_W-1:0]   in_code;
    logic [NUM_CH-1:0]               in_span;
    logic [NUM_CH-1:0][CODE_W-1:0]   out_code;
    logic [NUM_CH-1:0]               out_span;
    logic [NUM_CH-1:0][LEVEL_W-1:0]  out_level;
    logic                            load_event;
    logic                            short_word;
  } qdl_dev_state_t;

  localparam qdl_dev_state_t ST_RESET = '{
    clk_sync:   '1,
    data_sync:  '0,
    load_sync:  '1,
    // update idles low after a host reset, so no false fall follows release
    upd_sync:   '0,
    shift:      WORD_RESET,
    bit_count:  '0,
    in_code:    {NUM_CH{CODE_RESET}},
    in_span:    {NUM_CH{SPAN_RESET}},
    out_code:   {NUM_CH{CODE_RESET}},
    out_span:   {NUM_CH{SPAN_RESET}},
    out_level:  '0,
    load_event: 1'b0,
    short_word: 1'b0
  };

  qdl_dev_state_t st_reg;
  qdl_dev_state_t st_next;

  logic             clk_fall;
  logic             load_fall;
  logic             upd_fall;
  logic             load_high;
  logic             upd_low;
  logic             data_bit;
  logic [SEL_W-1:0] sel;

  // output level in units of reference/256: code, doubled when span is set
  function automatic logic [LEVEL_W-1:0] qdl_level
  (
    input logic [CODE_W-1:0] code,
    input logic              span
  );
    logic [LEVEL_W-1:0] lvl;
    lvl = {1'b0, code};
    if (span)
    begin
      lvl = {code, 1'b0};
    end
    return lvl;
  endfunction : qdl_level

  // stage 1 feeds stage 2 only; edges come from stages 2 and 3
  assign clk_fall  = st_reg.clk_sync[2] & ~st_reg.clk_sync[1];
  assign load_fall = st_reg.load_sync[2] & ~st_reg.load_sync[1];
  assign upd_fall  = st_reg.upd_sync[2] & ~st_reg.upd_sync[1];
  assign load_high = st_reg.load_sync[1];
  assign upd_low   = ~st_reg.upd_sync[1];
  assign data_bit  = st_reg.data_sync[1];
  assign sel       = st_reg.shift[SEL_HI_POS:SEL_LO_POS];

  always_comb
  begin
    st_next = st_reg;
    st_next.clk_sync  = {st_reg.clk_sync[SYNC_DEPTH-2:0], link.ser_clk};
    st_next.data_sync = {st_reg.data_sync[SYNC_DEPTH-2:0], link.ser_data};
    st_next.load_sync = {st_reg.load_sync[SYNC_DEPTH-2:0], link.load_n};
    st_next.upd_sync  = {st_reg.upd_sync[SYNC_DEPTH-2:0], link.output_update_strobe_n};
    st_next.load_event = 1'b0;

    // the shift register is exactly one word wide, so older bits fall out
    if (clk_fall && load_high)
    begin
      st_next.shift = {st_reg.shift[WORD_W-2:0], data_bit};
      if (st_reg.bit_count != BITS_FULL)
      begin
        st_next.bit_count = st_reg.bit_count + 4'h1;
      end
    end

    if (load_fall)
    begin
      st_next.in_code[sel] = st_reg.shift[CODE_MSB_POS:CODE_LSB_POS];
      st_next.in_span[sel] = st_reg.shift[SPAN_POS];
      st_next.load_event = 1'b1;
      st_next.short_word = (st_reg.bit_count != BITS_FULL);
      st_next.bit_count  = '0;
      if (upd_low)
      begin
        st_next.out_code[sel] = st_next.in_code[sel];
        st_next.out_span[sel] = st_next.in_span[sel];
      end
    end

    // taken after the load so a word loaded in the same cycle is included
    if (upd_fall)
    begin
      st_next.out_code = st_next.in_code;
      st_next.out_span = st_next.in_span;
    end

    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      st_next.out_level[ch] = qdl_level(st_next.out_code[ch], st_next.out_span[ch]);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign channel_out_0   = st_reg.out_code[0];
  assign channel_out_1   = st_reg.out_code[1];
  assign channel_out_2   = st_reg.out_code[2];
  assign channel_out_3   = st_reg.out_code[3];
  assign span_double_0   = st_reg.out_span[0];
  assign span_double_1   = st_reg.out_span[1];
  assign span_double_2   = st_reg.out_span[2];
  assign span_double_3   = st_reg.out_span[3];
  assign channel_level_0 = st_reg.out_level[0];
  assign channel_level_1 = st_reg.out_level[1];
  assign channel_level_2 = st_reg.out_level[2];
  assign channel_level_3 = st_reg.out_level[3];
  assign load_event      = st_reg.load_event;
  assign short_word      = st_reg.short_word;

endmodule : qdl_device
`default_nettype wire

// File: core/qdl_host.sv
// host end: avalon slave registers driving the serial command link
`timescale 1ns/100ps
`default_nettype none
module qdl_host
  import qdl_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  qdl_link_if.host                   link,
  input  wire logic [AVS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [AVS_DATA_W-1:0] avs_writedata,
  output logic      [AVS_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest
);

  typedef enum logic [6:0] {
    HS_IDLE    = 7'h01,
    HS_CLK_HI  = 7'h02,
    HS_CLK_LO  = 7'h04,
    HS_LOAD    = 7'h08,
    HS_GAP     = 7'h10,
    HS_UPD_PRE = 7'h20,
    HS_UPD     = 7'h40
  } qdl_hstate_t;

  typedef struct packed {
    qdl_hstate_t           fsm;
    logic [TIMER_W-1:0]    timer;
    logic [BITCNT_W-1:0]   bits_left;
    logic [WORD_W-1:0]     word;
    logic [WORD_W-1:0]     last_word;
    logic                  pend;
    logic                  upd_req;
    logic                  hold;
    logic                  ser_clk;
    logic                  ser_data;
    logic                  load_n;
    logic                  upd_n;
    logic                  waitreq;
    logic [AVS_DATA_W-1:0] rdata;
  } qdl_host_state_t;

  localparam qdl_host_state_t ST_RESET = '{
    fsm:       HS_IDLE,
    timer:     TIMER_ZERO,
    bits_left: '0,
    word:      WORD_RESET,
    last_word: WORD_RESET,
    pend:      1'b0,
    upd_req:   1'b0,
    hold:      1'b0,
    ser_clk:   1'b1,
    ser_data:  1'b0,
    load_n:    1'b1,
    upd_n:     1'b0,
    waitreq:   1'b1,
    rdata:     RDATA_RESET
  };

  qdl_host_state_t st_reg;
  qdl_host_state_t st_next;

  logic busy;
  logic req;
  logic blocked;
  logic timer_done;

  assign busy       = st_reg.pend | st_reg.upd_req | (st_reg.fsm != HS_IDLE);
  assign req        = avs_read | avs_write;
  assign timer_done = (st_reg.timer == TIMER_ZERO);
  // a new command or update pulse waits until the link is quiet
  assign blocked    = avs_write & busy &
                      ((avs_address == REG_CMD) |
                       ((avs_address == REG_CTRL) & avs_writedata[CTRL_PULSE_POS]));

  always_comb
  begin
    st_next = st_reg;
    st_next.waitreq = 1'b1;
    if (!timer_done)
    begin
      st_next.timer = st_reg.timer - 5'h01;
    end

    // bus side: one wait cycle, then the answer at the edge wait is low
    if (req && st_reg.waitreq && !blocked)
    begin
      st_next.waitreq = 1'b0;
      st_next.rdata   = RDATA_RESET;
      case (avs_address)
        REG_CMD:    st_next.rdata[WORD_W-1:0]    = st_reg.last_word;
        REG_CTRL:   st_next.rdata[CTRL_HOLD_POS] = st_reg.hold;
        REG_STATUS:
        begin
          st_next.rdata[STAT_BUSY_POS] = busy;
          st_next.rdata[STAT_PEND_POS] = st_reg.pend;
          st_next.rdata[STAT_UPD_POS]  = st_reg.upd_req;
        end
        default:    st_next.rdata = RDATA_RESET;
      endcase
    end
    if (avs_write && !st_reg.waitreq)
    begin
      if (avs_address == REG_CMD)
      begin
        st_next.word      = avs_writedata[WORD_W-1:0];
        st_next.last_word = avs_writedata[WORD_W-1:0];
        st_next.pend      = 1'b1;
      end
      if (avs_address == REG_CTRL)
      begin
        st_next.hold = avs_writedata[CTRL_HOLD_POS];
        if (avs_writedata[CTRL_PULSE_POS])
        begin
          st_next.upd_req = 1'b1;
        end
      end
    end

    // link side
    case (st_reg.fsm)
      HS_IDLE:
      begin
        st_next.upd_n = st_next.hold;
        if (st_reg.pend)
        begin
          st_next.ser_data  = st_reg.word[WORD_W-1];
          st_next.bits_left = BITS_FULL - 4'h1;
          st_next.timer     = HALF_RELOAD;
          st_next.fsm       = HS_CLK_HI;
        end
        else if (st_reg.upd_req)
        begin
          st_next.upd_n = 1'b1;
          st_next.timer = HALF_RELOAD;
          st_next.fsm   = HS_UPD_PRE;
        end
      end
      HS_CLK_HI:
        if (timer_done)
        begin
          st_next.ser_clk = 1'b0;
          st_next.timer   = HALF_RELOAD;
          st_next.fsm     = HS_CLK_LO;
        end
      HS_CLK_LO:
        if (timer_done)
        begin
          st_next.ser_clk = 1'b1;
          st_next.timer   = HALF_RELOAD;
          if (st_reg.bits_left == '0)
          begin
            st_next.fsm = HS_LOAD;
          end
          else
          begin
            st_next.word      = {st_reg.word[WORD_W-2:0], 1'b0};
            st_next.ser_data  = st_reg.word[WORD_W-2];
            st_next.bits_left = st_reg.bits_left - 4'h1;
            st_next.fsm       = HS_CLK_HI;
          end
        end
      HS_LOAD:
        if (timer_done && st_reg.load_n)
        begin
          st_next.load_n = 1'b0;
          st_next.timer  = PULSE_RELOAD;
        end
        else if (timer_done)
        begin
          st_next.load_n = 1'b1;
          st_next.timer  = HALF_RELOAD;
          st_next.fsm    = HS_GAP;
        end
      HS_GAP:
        if (timer_done)
        begin
          st_next.pend = 1'b0;
          st_next.fsm  = HS_IDLE;
        end
      HS_UPD_PRE:
        if (timer_done)
        begin
          st_next.upd_n = 1'b0;
          st_next.timer = PULSE_RELOAD;
          st_next.fsm   = HS_UPD;
        end
      HS_UPD:
        if (timer_done)
        begin
          st_next.upd_n   = st_reg.hold;
          st_next.upd_req = 1'b0;
          st_next.timer   = HALF_RELOAD;
          st_next.fsm     = HS_GAP;
        end
      default:
        st_next.fsm = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign link.ser_clk                = st_reg.ser_clk;
  assign link.ser_data               = st_reg.ser_data;
  assign link.load_n                 = st_reg.load_n;
  assign link.output_update_strobe_n = st_reg.upd_n;
  assign avs_readdata                = st_reg.rdata;
  assign avs_waitrequest             = st_reg.waitreq;

endmodule : qdl_host
`default_nettype wire

// File: sim/qdl_link_properties.sv
// link checker for the quad code loader
`timescale 1ns/100ps
`default_nettype none
module qdl_link_properties
  import qdl_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire logic               ser_clk,
  input wire logic               ser_data,
  input wire logic               load_n,
  input wire logic               output_update_strobe_n,
  input wire logic [CODE_W-1:0]  channel_out_0,
  input wire logic               span_double_0,
  input wire logic [LEVEL_W-1:0] channel_level_0,
  input wire logic               load_event
);
  logic                clk_q;
  logic [BITCNT_W-1:0] falls;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // serial clock falls since the last load pulse
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      clk_q <= 1'b1;
      falls <= '0;
    end
    else
    begin
      clk_q <= ser_clk;
      if (!load_n)
        falls <= '0;
      else if (clk_q && !ser_clk)
        falls <= falls + 4'h1;
    end

  chk_load_clk_high: assert property (!load_n |-> ser_clk)
    else $error("serial clock low during load pulse");
  chk_frame_bits: assert property ($fell(load_n) |-> falls == BITS_FULL)
    else $error("load pulse not after eleven clock falls");
  chk_data_at_fall: assert property ($fell(ser_clk) |-> $stable(ser_data))
    else $error("serial data moved at clock fall");
  chk_load_width: assert property ($fell(load_n) |-> (!load_n)[*8])
    else $error("load pulse too short");
  chk_update_width: assert property ($fell(output_update_strobe_n) |-> (!output_update_strobe_n)[*8])
    else $error("update pulse too short");
  chk_event_after_load: assert property ($fell(load_n) |-> ##[2:5] load_event)
    else $error("no load event after load pulse");
  chk_event_single: assert property (load_event |=> !load_event)
    else $error("load event longer than one cycle");
  chk_level_span: assert property ($stable(channel_out_0) && $stable(span_double_0)
    |-> channel_level_0 == ({1'b0, channel_out_0} << span_double_0))
    else $error("level does not match code and span");
  chk_outputs_hold: assert property ($changed(channel_out_0)
    |-> $past(!load_n, 3) || $past(!output_update_strobe_n, 3))
    else $error("output changed without load or update");

  cover property ($fell(load_n));
  cover property ($fell(output_update_strobe_n) && load_n);
  cover property (load_event && span_double_0);
endmodule : qdl_link_properties
`default_nettype wire

// File: sim/quad_dac_serial_loader_bench.sv
// bench for host and converter ends of the quad code loader
`timescale 1ns/100ps
`default_nettype none
module quad_dac_serial_loader_bench
  import qdl_pkg::*;
;
  localparam logic [7:0] CODES [4] = '{8'hA5, 8'hFF, 8'h01, 8'h80};
  logic                  clk_sys = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [AVS_ADDR_W-1:0] av_addr;
  logic                  av_rd;
  logic                  av_wr;
  logic [AVS_DATA_W-1:0] av_wdata;
  logic [AVS_DATA_W-1:0] av_rdata;
  logic                  av_wait;
  logic [AVS_DATA_W-1:0] rd;
  logic [CODE_W-1:0]     out_a [4];
  logic [CODE_W-1:0]     out_b [4];
  logic                  sp_a [4];
  logic                  sp_b [4];
  logic [LEVEL_W-1:0]    lv_a [4];
  logic [LEVEL_W-1:0]    lv_b [4];
  logic                  ev_a;
  logic                  sw_b;
  int                    n_mismatch = 0;
  int                    comparisons = 0;
  int                    cycles = 0;

  qdl_link_if link_a ();
  qdl_link_if link_b ();

  always #12.5 clk_sys = ~clk_sys;

  qdl_host qdl_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_a), .avs_address(av_addr),
    .avs_read(av_rd), .avs_write(av_wr), .avs_writedata(av_wdata), .avs_readdata(av_rdata), .avs_waitrequest(av_wait));
  qdl_device qdl_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_a),
    .channel_out_0(out_a[0]), .channel_out_1(out_a[1]), .channel_out_2(out_a[2]), .channel_out_3(out_a[3]),
    .span_double_0(sp_a[0]), .span_double_1(sp_a[1]), .span_double_2(sp_a[2]), .span_double_3(sp_a[3]),
    .channel_level_0(lv_a[0]), .channel_level_1(lv_a[1]), .channel_level_2(lv_a[2]), .channel_level_3(lv_a[3]),
    .load_event(ev_a), .short_word());
  qdl_device qdl_device_inst_b (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_b),
    .channel_out_0(out_b[0]), .channel_out_1(out_b[1]), .channel_out_2(out_b[2]), .channel_out_3(out_b[3]),
    .span_double_0(sp_b[0]), .span_double_1(sp_b[1]), .span_double_2(sp_b[2]), .span_double_3(sp_b[3]),
    .channel_level_0(lv_b[0]), .channel_level_1(lv_b[1]), .channel_level_2(lv_b[2]), .channel_level_3(lv_b[3]),
    .load_event(), .short_word(sw_b));
  qdl_link_properties qdl_link_properties_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ser_clk(link_a.ser_clk),
    .ser_data(link_a.ser_data), .load_n(link_a.load_n), .output_update_strobe_n(link_a.output_update_strobe_n),
    .channel_out_0(out_a[0]), .span_double_0(sp_a[0]), .channel_level_0(lv_a[0]), .load_event(ev_a));

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task av_req(input logic [AVS_ADDR_W-1:0] a, input logic rnw, input logic [AVS_DATA_W-1:0] d);
    @(posedge clk_sys);
    av_addr <= a;
    av_rd <= rnw;
    av_wr <= !rnw;
    av_wdata <= d;
    do @(posedge clk_sys); while (av_wait !== 1'b0);
    rd = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : av_req

  // polls status until the host has nothing in flight
  task idle;
    do av_req(REG_STATUS, 1'b1, '0); while (rd[2:0] !== 3'h0);
  endtask : idle

  task chk_ch(input int c, input logic b, input logic [7:0] code, input logic sp);
    check("code", b ? out_b[c] : out_a[c], code);
    check("span", b ? sp_b[c] : sp_a[c], sp);
    check("level", b ? lv_b[c] : lv_a[c], {1'b0, code} << sp);
  endtask : chk_ch

  task lb_bits(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      link_b.ser_data <= w[i];
      repeat (4) @(posedge clk_sys);
      link_b.ser_clk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      link_b.ser_clk <= 1'b1;
    end
    // a released data line does not keep its last bit
    link_b.ser_data <= ~w[0];
  endtask : lb_bits

  task lb_load;
    repeat (4) @(posedge clk_sys);
    link_b.load_n <= 1'b0;
    repeat (11) @(posedge clk_sys);
    link_b.load_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : lb_load

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      test_done;
    end
  end

  initial
  begin
    av_addr <= '0;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    av_wdata <= '0;
    link_b.ser_clk <= 1'b1;
    link_b.ser_data <= 1'b0;
    link_b.load_n <= 1'b1;
    link_b.output_update_strobe_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int c = 0; c < 4; c++)
      chk_ch(c, 1'b0, 8'h00, 1'b0);
    for (int c = 0; c < 4; c++)
      av_req(REG_CMD, 1'b0, {21'h0, c[1:0], c[0], CODES[c]});
    idle;
    for (int c = 0; c < 4; c++)
      chk_ch(c, 1'b0, CODES[c], c[0]);
    av_req(REG_CMD, 1'b1, '0);
    check("cmd readback", rd, {21'h0, 2'h3, 1'b1, 8'h80});
    av_req(2'h3, 1'b1, '0);
    check("unmapped read", rd, 32'h0000_0000);
    // deferred update with the strobe held high
    av_req(REG_CTRL, 1'b0, 32'h0000_0001);
    av_req(REG_CMD, 1'b0, {21'h0, 2'h2, 1'b0, 8'h3C});
    idle;
    chk_ch(2, 1'b0, CODES[2], 1'b0);
    av_req(REG_CTRL, 1'b0, 32'h0000_0003);
    idle;
    chk_ch(2, 1'b0, 8'h3C, 1'b0);
    av_req(REG_CTRL, 1'b1, '0);
    check("hold readback", rd, 32'h0000_0001);
    // two byte bursts, five leading bits to be dropped
    lb_bits(16'h00FB, 8);
    repeat (20) @(posedge clk_sys);
    lb_bits(16'h005A, 8);
    lb_load;
    chk_ch(1, 1'b1, 8'h5A, 1'b1);
    check("short flag", sw_b, 1'b0);
    lb_bits(16'h16C3, 13);
    lb_load;
    chk_ch(3, 1'b1, 8'hC3, 1'b0);
    lb_bits(16'h0005, 5);
    lb_load;
    check("short flag", sw_b, 1'b1);
    test_done;
  end
endmodule : quad_dac_serial_loader_bench
`default_nettype wire
